// *** hw/bmsb_framer.sv ***
// brightness and mode serial framer with avalon-mm registers
// What this block does
// - send two consecutive eight-bit words on one serial line
// - first word is brightness, second word is mode information
// - words carry brightness, low-voltage flag, mode and display information
// - mode bits auto 00, battery 01, flash one 10, flash two 11
// - every data bit active low: line low means one
// - slot n carries weight two to the power n
// - least significant bit in the earliest slot, except the two mode bits, which go mode[1] first (slot 3 of the word)
// - brightness word is plain unsigned binary
// - word boundaries aligned to the periodic frame trigger
// - flash ready forces shutter selection to one sixtieth, except a slow dial in manual flash
// - manual flash with flash ready: fast dial gives 1/60, slow dial passes through
// - brightness word is sent as zero until three conversion units after metering starts
`timescale 1ns/1ns
`include "bmsb_defines.svh"
module bmsb_framer
  import bmsb_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  // avalon-mm slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // pins from other chips
  input  wire logic        bit_clock,
  input  wire logic        frame_trigger,
  input  wire logic        conv_unit,
  input  wire logic        flash_ready_current,
  input  wire logic        flash_manual_mode,
  // serial output, active low
  output logic             bus_out_n
);
  logic rst_a_r;
  logic rst_n_r;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_a_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_a_r <= 1'b1;
      rst_n_r <= rst_a_r;
    end
  end

  // pins cross into clk_sys
  logic clk_s;
  logic trig_s;
  logic unit_s;
  logic frc_s;
  logic man_s;
  bmsb_sync2 u_clk (.clk_sys(clk_sys), .rst_n(rst_n_r), .d(bit_clock), .q(clk_s));
  bmsb_sync2 u_trg (.clk_sys(clk_sys), .rst_n(rst_n_r), .d(frame_trigger), .q(trig_s));
  bmsb_sync2 u_unt (.clk_sys(clk_sys), .rst_n(rst_n_r), .d(conv_unit), .q(unit_s));
  bmsb_sync2 u_frc (.clk_sys(clk_sys), .rst_n(rst_n_r), .d(flash_ready_current),
                    .q(frc_s));
  bmsb_sync2 u_man (.clk_sys(clk_sys), .rst_n(rst_n_r), .d(flash_manual_mode), .q(man_s));

  logic clk_d_r;
  logic trig_d_r;
  logic unit_d_r;
  logic clk_fall;
  logic trig_rise;
  logic unit_rise;
  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      clk_d_r  <= 1'b0;
      trig_d_r <= 1'b0;
      unit_d_r <= 1'b0;
    end else begin
      clk_d_r  <= clk_s;
      trig_d_r <= trig_s;
      unit_d_r <= unit_s;
    end
  end
  // data changes on the falling edge so the receiver samples on the rise
  assign clk_fall  = clk_d_r & ~clk_s;
  assign trig_rise = trig_s & ~trig_d_r;
  assign unit_rise = unit_s & ~unit_d_r;

  // software registers
  logic        meter_en_r;
  bmsb_frame_t shadow_r;
  logic [7:0]  dial_r;
  logic [7:0]  speed_r;
  logic        ack_r;
  logic        frame_busy;
  logic [1:0]  frames_r;
  logic        bus_req;
  logic [7:0]  speed_nxt;

  // writes land on the edge where waitrequest is seen low, never earlier
  function automatic logic wr_hit(input logic       wr,
                                  input logic       ackd,
                                  input logic [3:0] addr,
                                  input logic [3:0] target);
    wr_hit = wr && ackd && (addr == target);
  endfunction

  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      meter_en_r <= 1'b0;
    end else if (wr_hit(avs_write, ack_r, avs_address, `BMSB_ADDR_CTRL)) begin
      meter_en_r <= avs_writedata[0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      shadow_r <= '0;
    end else if (wr_hit(avs_write, ack_r, avs_address, `BMSB_ADDR_DATA)) begin
      shadow_r.brightness_value <= avs_writedata[7:0];
      shadow_r.mode             <= avs_writedata[9:8];
      shadow_r.low_voltage_flag <= avs_writedata[10];
      shadow_r.display_info     <= avs_writedata[11];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      dial_r <= 8'h00;
    end else if (wr_hit(avs_write, ack_r, avs_address, `BMSB_ADDR_SHUTTER)) begin
      dial_r <= avs_writedata[7:0];
    end
  end

  // dial code: larger value means slower; codes at or above 1/30 are slow
  function automatic logic [7:0] pick_speed(input logic ready, input logic manual,
                                             input logic [7:0] dial);
    if (manual && ready) begin
      pick_speed = (dial >= `BMSB_SPEED_30) ? dial : `BMSB_SPEED_60;
    end else if (ready) begin
      pick_speed = `BMSB_SPEED_60;
    end else begin
      pick_speed = dial;
    end
  endfunction

  assign speed_nxt = pick_speed(frc_s, man_s, dial_r);

  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      speed_r <= 8'h00;
    end else begin
      speed_r <= speed_nxt;
    end
  end

  // one wait state on every access
  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= bus_req && !ack_r;
    end
  end
  // combinational so the second cycle of every request is the answering one
  assign bus_req         = avs_read || avs_write;
  assign avs_waitrequest = bus_req && !ack_r;

  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !ack_r) begin
      if (avs_address == `BMSB_ADDR_CTRL) begin
        avs_readdata <= {31'h0000_0000, meter_en_r};
      end else if (avs_address == `BMSB_ADDR_DATA) begin
        avs_readdata <= {20'h00000, shadow_r.display_info, shadow_r.low_voltage_flag,
                         shadow_r.mode, shadow_r.brightness_value};
      end else if (avs_address == `BMSB_ADDR_SHUTTER) begin
        avs_readdata <= {16'h0000, speed_r, dial_r};
      end else if (avs_address == `BMSB_ADDR_STATUS) begin
        avs_readdata <= {28'h0000000, frames_r, frame_busy, 1'b0};
      end else begin
        avs_readdata <= 32'h0000_0000;
      end
    end
  end

  // stabilisation after metering starts
  logic [1:0] stab_r;
  logic       stab_done;
  assign stab_done = (stab_r == 2'(`BMSB_STAB_UNITS));
  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      stab_r <= 2'h0;
    end else if (!meter_en_r) begin
      stab_r <= 2'h0;
    end else if (unit_rise && !stab_done) begin
      stab_r <= stab_r + 2'h1;
    end
  end

  // frame engine
  bmsb_state_t state_r;
  logic [3:0]  slot_r;
  logic [15:0] frame_r;
  logic        frame_start;
  logic        frame_end;
  assign frame_busy  = (state_r == BMSB_SEND);
  // a trigger seen while a frame runs is ignored
  assign frame_start = (state_r == BMSB_IDLE) && trig_rise && meter_en_r;
  assign frame_end   = (state_r == BMSB_SEND) && clk_fall && (slot_r == 4'hF);

  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r <= BMSB_IDLE;
    end else begin
      case (state_r)
        BMSB_IDLE: begin
          if (frame_start) begin
            state_r <= BMSB_WAIT;
          end
        end
        BMSB_WAIT: begin
          if (clk_fall) begin
            state_r <= BMSB_SEND;
          end
        end
        BMSB_SEND: begin
          if (frame_end) begin
            state_r <= BMSB_IDLE;
          end
        end
        default: state_r <= BMSB_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      slot_r <= 4'h0;
    end else if (state_r != BMSB_SEND) begin
      slot_r <= 4'h0;
    end else if (clk_fall) begin
      slot_r <= slot_r + 4'h1;
    end
  end

  // brightness stays zero until the sensor has had time to settle
  function automatic logic [7:0] bright_word(input logic       settled,
                                             input logic [7:0] value);
    bright_word = settled ? value : 8'h00;
  endfunction

  // unused slots of the mode word stay at logic zero, a high line
  function automatic logic [7:0] mode_word(input bmsb_frame_t f);
    mode_word                  = 8'h00;
    mode_word[`BMSB_MODE0_POS] = f.mode[1];
    mode_word[`BMSB_MODE1_POS] = f.mode[0];
    mode_word[`BMSB_LV_POS]    = f.low_voltage_flag;
    mode_word[`BMSB_DISPLAY_INFO_POS]  = f.display_info;
  endfunction

  // latched at the trigger only, so both words of a frame agree
  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      frame_r <= 16'h0000;
    end else if (frame_start) begin
      frame_r[7:0]  <= bright_word(stab_done, shadow_r.brightness_value);
      frame_r[15:8] <= mode_word(shadow_r);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      frames_r <= 2'h0;
    end else if (frame_end) begin
      frames_r <= frames_r + 2'h1;
    end
  end

  // line low means one; after the last slot the line goes back high
  function automatic logic next_level(input logic [15:0] f,
                                      input logic [3:0]  slot,
                                      input logic        first);
    if (first) begin
      next_level = ~f[0];
    end else if (slot == 4'hF) begin
      next_level = 1'b1;
    end else begin
      next_level = ~f[slot + 4'h1];
    end
  endfunction

  // brightness word in slots 0-7, mode word in 8-15, lsb first
  always_ff @(posedge clk_sys or negedge rst_n_r) begin
    if (!rst_n_r) begin
      bus_out_n <= 1'b1;
    end else if (state_r == BMSB_SEND || (state_r == BMSB_WAIT && clk_fall)) begin
      if (clk_fall) begin
        bus_out_n <= next_level(frame_r, slot_r, state_r == BMSB_WAIT);
      end
    end else begin
      bus_out_n <= 1'b1;
    end
  end
endmodule

// *** hw/bmsb_sync2.sv ***
// two-flop synchroniser for pin inputs
`timescale 1ns/1ns
module bmsb_sync2 (
  // clock and reset
  input  wire  clk_sys,
  input  wire  rst_n,
  // data
  input  wire  d,
  output logic q
);
  logic meta_r;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= 1'b0;
      q      <= 1'b0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

// *** shared/bmsb_defines.svh ***
// constants for the brightness and mode serial framer
`ifndef BMSB_DEFINES_SVH
`define BMSB_DEFINES_SVH
`define BMSB_WORD_BITS      8
`define BMSB_WORDS          2
`define BMSB_STAB_UNITS     3
`define BMSB_MODE0_POS      3
`define BMSB_MODE1_POS      4
`define BMSB_LV_POS         5
`define BMSB_DISPLAY_INFO_POS       7
`define BMSB_ADDR_CTRL      4'h0
`define BMSB_ADDR_DATA      4'h4
`define BMSB_ADDR_SHUTTER   4'h8
`define BMSB_ADDR_STATUS    4'hC
`define BMSB_CTRL_RST       8'h00
`define BMSB_SPEED_60       8'h3C
`define BMSB_SPEED_30       8'h40
`endif

// *** shared/bmsb_pkg.sv ***
// types for the brightness and mode serial framer
package bmsb_pkg;
  typedef enum logic [1:0] {
    BMSB_MODE_AUTO    = 2'h0,
    BMSB_MODE_BATT    = 2'h1,
    BMSB_MODE_FLASH1  = 2'h2,
    BMSB_MODE_FLASH2  = 2'h3
  } bmsb_mode_t;
  typedef struct packed {
    logic [7:0] brightness_value;
    logic [1:0] mode;
    logic       low_voltage_flag;
    logic       display_info;
  } bmsb_frame_t;
  typedef enum logic [1:0] {
    BMSB_IDLE = 2'h0,
    BMSB_WAIT = 2'h1,
    BMSB_SEND = 2'h3
  } bmsb_state_t;
endpackage

// *** test/bmsb_framer_monitor.sv ***
// assertion checker for the framer ports
`timescale 1ns/1ns
module bmsb_framer_monitor (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        reset_n,
  // register bus
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // pins
  input wire logic        bit_clock,
  input wire logic        frame_trigger,
  input wire logic        flash_ready_current,
  input wire logic        flash_manual_mode,
  input wire logic        bus_out_n
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  logic [4:0] since_fall_r;
  wire        req   = avs_read || avs_write;
  wire        rd_ok = avs_read && !avs_waitrequest;
  wire [7:0]  dial  = avs_readdata[7:0];
  wire [7:0]  sel   = avs_readdata[15:8];
  // saturates well above one bit period, so 31 means no frame running
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n)
      since_fall_r <= 5'h1F;
    else if ($fell(bit_clock))
      since_fall_r <= 5'h00;
    else if (since_fall_r != 5'h1F)
      since_fall_r <= since_fall_r + 5'h01;
  end
  sequence s_one_wait;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  sequence s_quiet3;
    bus_out_n [*3];
  endsequence
  sequence s_sh(logic r, logic m);
    rd_ok && avs_address == 4'h8 && flash_ready_current == r && flash_manual_mode == m
      && $past(flash_ready_current, 3) == r && $past(flash_manual_mode, 3) == m;
  endsequence
  AST_WAIT_FIRST: assert property ($rose(req) |-> s_one_wait)
    else $error("request not answered after one wait state");
  AST_UNMAPPED_ZERO: assert property (rd_ok && avs_address[1:0] != 2'h0 |-> avs_readdata == 0)
    else $error("unmapped read not zero");
  AST_LINE_ON_FALL: assert property ($changed(bus_out_n) |-> since_fall_r <= 5'h08)
    else $error("line changed away from a bit clock fall");
  AST_IDLE_HIGH: assert property (since_fall_r == 5'h1F |-> bus_out_n)
    else $error("line not high between frames");
  AST_QUIET_AFTER_TRIG: assert property (
    $rose(frame_trigger) && since_fall_r == 5'h1F |-> s_quiet3)
    else $error("line moved before first bit clock fall");
  AST_FLASH_FORCE: assert property (s_sh(1'b1, 1'b0) |-> sel == 8'h3C)
    else $error("flash ready did not force 1/60");
  AST_MANUAL_SPEED: assert property (
    s_sh(1'b1, 1'b1) |-> sel == (dial >= 8'h40 ? dial : 8'h3C))
    else $error("manual flash speed wrong");
  AST_DIAL_PASS: assert property (s_sh(1'b0, flash_manual_mode) |-> sel == dial)
    else $error("dial not passed through");
endmodule
bind bmsb_framer bmsb_framer_monitor u_bmsb_framer_monitor (.clk_sys(clk_sys),
  .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .bit_clock(bit_clock),
  .frame_trigger(frame_trigger), .flash_ready_current(flash_ready_current),
  .flash_manual_mode(flash_manual_mode), .bus_out_n(bus_out_n));

// *** test/bmsb_rx_model.sv ***
// receiving processor model: makes trigger and bit clock, collects a frame
`timescale 1ns/1ns
module bmsb_rx_model (
  // clock
  input wire logic clk_sys,
  // link
  input wire logic bus_out_n,
  output logic     bit_clock,
  output logic     frame_trigger
);
  initial begin
    bit_clock = 1'b1;
    frame_trigger = 1'b0;
  end
  // bit clock only runs inside a frame; 17th fall ends the frame
  task automatic frame(output logic [15:0] bits);
    int i;
    @(posedge clk_sys);
    frame_trigger <= 1'b1;
    repeat (4) @(posedge clk_sys);
    frame_trigger <= 1'b0;
    repeat (4) @(posedge clk_sys);
    for (i = 0; i < 17; i++) begin
      bit_clock <= 1'b0;
      repeat (10) @(posedge clk_sys);
      bit_clock <= 1'b1;
      repeat (10) @(posedge clk_sys);
      if (i < 16)
        bits[i] = !bus_out_n;
    end
  endtask
endmodule

// *** test/brightness_mode_serial_bus_bench.sv ***
// self-checking bench for the serial framer
`timescale 1ns/1ns
module brightness_mode_serial_bus_bench;
  logic        clk_sys = 1'b0, reset_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd, lfsr = 32'h1875;
  logic        avs_waitrequest, bit_clock, frame_trigger, bus_out_n, conv_unit = 1'b0;
  logic        flash_ready_current = 1'b0, flash_manual_mode = 1'b0;
  logic [15:0] bits;
  logic [7:0]  cor [4] = '{8'h00, 8'h3F, 8'h40, 8'hFF};
  int          error_cnt = 0, comparisons = 0, cycles = 0;
  always #50 clk_sys = ~clk_sys;
  bmsb_framer u_bmsb_framer (.clk_sys(clk_sys), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .bit_clock(bit_clock),
    .frame_trigger(frame_trigger), .conv_unit(conv_unit),
    .flash_ready_current(flash_ready_current), .flash_manual_mode(flash_manual_mode),
    .bus_out_n(bus_out_n));
  bmsb_rx_model u_bmsb_rx_model (.clk_sys(clk_sys), .bus_out_n(bus_out_n),
    .bit_clock(bit_clock), .frame_trigger(frame_trigger));
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  function automatic logic [15:0] exp_frame(logic [11:0] d);
    return {d[11], 1'b0, d[10], d[8], d[9], 3'h0, d[7:0]};
  endfunction
  function automatic logic [7:0] exp_speed(logic [7:0] dl, logic rdy, logic man);
    return (rdy && (!man || dl < 8'h40)) ? 8'h3C : dl;
  endfunction
  task automatic check(logic [31:0] got, logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(logic wr, logic [3:0] a, logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic finish_test();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      finish_test();
    end
  end
  initial begin
    logic [11:0] d, old;
    logic [7:0]  dl;
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    bus(1'b0, 4'h0, 32'h0);
    check(rd, 32'h0);
    bus(1'b0, 4'h2, 32'h0);
    check(rd, 32'h0);
    d = 12'hE5C;
    bus(1'b1, 4'h4, {20'h0, d});
    bus(1'b1, 4'h0, 32'h1);
    u_bmsb_rx_model.frame(bits);
    check({16'h0, bits}, {16'h0, exp_frame({d[11:8], 8'h00})});
    repeat (3) begin
      @(posedge clk_sys) conv_unit <= 1'b1;
      repeat (4) @(posedge clk_sys);
      conv_unit <= 1'b0;
      repeat (4) @(posedge clk_sys);
    end
    for (int k = 0; k < 6; k++) begin
      d = 12'(rnd());
      d[9:8] = k[1:0];
      if (k < 2)
        d[7:0] = k ? 8'h01 : 8'hFF;
      bus(1'b1, 4'h4, {20'h0, d});
      u_bmsb_rx_model.frame(bits);
      check({16'h0, bits}, {16'h0, exp_frame(d)});
    end
    old = d;
    d = ~old;
    fork
      u_bmsb_rx_model.frame(bits);
      begin
        repeat (100) @(posedge clk_sys);
        bus(1'b1, 4'h4, {20'h0, d});
      end
    join
    check({16'h0, bits}, {16'h0, exp_frame(old)});
    u_bmsb_rx_model.frame(bits);
    check({16'h0, bits}, {16'h0, exp_frame(d)});
    repeat (5) @(posedge clk_sys);
    check({31'h0, bus_out_n}, 32'h1);
    // nine frames so far: count wraps to one, engine idle
    bus(1'b0, 4'hC, 32'h0);
    check(rd, 32'h4);
    for (int k = 0; k < 24; k++) begin
      dl = k < 16 ? cor[k[3:2]] : 8'(rnd());
      flash_ready_current <= k[0];
      flash_manual_mode <= k[1];
      bus(1'b1, 4'h8, {24'h0, dl});
      repeat (4) @(posedge clk_sys);
      bus(1'b0, 4'h8, 32'h0);
      check(rd, {16'h0, exp_speed(dl, k[0], k[1]), dl});
    end
    // reset in mid-run clears the word contents and idles the line
    reset_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    check({31'h0, bus_out_n}, 32'h1);
    bus(1'b0, 4'h4, 32'h0);
    check(rd, 32'h0);
    finish_test();
  end
endmodule
